// ==== i2c_eeprom_params.svh ====
`ifndef I2C_EEPROM_PARAMS_SVH
`define I2C_EEPROM_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define EE_CLK_PERIOD_NS       100
// Longest internal program time, rounded down to whole cycles
`define EE_PROG_TIME_NS        5000000
`define EE_PROG_CYCLES         (`EE_PROG_TIME_NS / `EE_CLK_PERIOD_NS)
// Serial clock made by the master end
`define EE_SCL_PERIOD_NS       800
`define EE_SCL_QUARTER_CYCLES  (`EE_SCL_PERIOD_NS / (4 * `EE_CLK_PERIOD_NS))

// ----------------------------------------------------------------
// Array layout and frame fields
// ----------------------------------------------------------------
`define EE_ADDR_W              12
`define EE_MEM_BYTES           4096
`define EE_PAGE_BYTES          32
`define EE_ROW_LSB             5
`define EE_BITS_PER_BYTE       8
`define EE_ACK_SLOT            9
`define EE_ADDR_HI_MSB         3
`define EE_MEM_ERASED          8'hFF

`endif

// ==== i2c_eeprom_pkg.sv ====
package i2c_eeprom_pkg;

  // ----------------------------------------------------------------
  // Device end states, Gray coded along idle-rx-tx
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_RX   = 2'h1,
    DEV_TX   = 2'h3,
    DEV_PROG = 2'h2
  } dev_state_t;

  // Which byte of a frame the device is receiving
  typedef enum logic [1:0] {
    KIND_SELECT  = 2'h0,
    KIND_ADDR_HI = 2'h1,
    KIND_ADDR_LO = 2'h3,
    KIND_DATA    = 2'h2
  } byte_kind_t;

  // Master end states
  typedef enum logic [1:0] {
    MST_IDLE  = 2'h0,
    MST_START = 2'h1,
    MST_BIT   = 2'h3,
    MST_STOP  = 2'h2
  } mst_state_t;

  // Bus primitives the master user can request
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } bus_op_t;

endpackage : i2c_eeprom_pkg

// ==== i2c_link_if.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Two-wire link between master end and device end
// ----------------------------------------------------------------
interface i2c_link_if;
  logic scl;       // Serial clock, driven by the master end
  logic sda_m_o;   // Master data output value
  logic sda_m_oe;  // Master drives data line
  logic sda_s_o;   // Device data output value
  logic sda_s_oe;  // Device drives data line
  logic sda;       // Resolved wired-and data line

  // Pull-up wins unless an end drives the line
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface : i2c_link_if

// ==== i2c_bus_master.sv ====
`timescale 1ns/1ns
`include "i2c_eeprom_params.svh"
// ----------------------------------------------------------------
// Byte level bus master: start, write byte, read byte, stop
// ----------------------------------------------------------------
module i2c_bus_master
  import i2c_eeprom_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES = `EE_SCL_QUARTER_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       srst,
  i2c_link_if.master      link,
  input  wire logic       cmd_valid,
  input  wire bus_op_t    cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_ack_send,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack
);

  localparam int unsigned DW = $clog2(QUARTER_CYCLES + 1);

  typedef struct packed {
    mst_state_t    state;   // Current primitive
    logic [DW-1:0] div;     // Quarter period divider
    logic [1:0]    qtr;     // Quarter within a bit
    logic [3:0]    bitn;    // Bit index within the nine
    logic [8:0]    tx;      // Bits to put out, msb first
    logic [8:0]    rx;      // Bits sampled back
    logic          scl;     // Clock level driven out
    logic          sda_oe;  // Pull data low
    logic [1:0]    sda_sy;  // Data line synchroniser
    logic          ready;
    logic          rsp_v;
    logic [7:0]    rsp_d;
    logic          rsp_a;
  } mst_regs_t;

  mst_regs_t r;     // State
  mst_regs_t n;     // Next state
  logic      tick;  // Quarter boundary

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = r;
    n.rsp_v  = 1'b0;
    n.sda_sy = {r.sda_sy[0], link.sda};
    tick     = (r.div == DW'(QUARTER_CYCLES - 1));
    if (r.state == MST_IDLE) begin
      n.div = '0;
      n.qtr = 2'h0;
      if (cmd_valid && r.ready) begin
        n.ready = 1'b0;
        n.bitn  = 4'h0;
        unique case (cmd_op)
          OP_START: n.state = MST_START;
          OP_STOP:  n.state = MST_STOP;   // Ends a frame, write or read
          OP_WRITE: begin
            n.state  = MST_BIT;
            n.tx     = {cmd_data, 1'b1};  // Release line for the ack
            n.sda_oe = ~cmd_data[7];
          end
          OP_READ: begin
            // Ack keeps a sequential read going, no ack ends it
            n.state  = MST_BIT;
            n.tx     = {8'hFF, ~cmd_ack_send};
            n.sda_oe = 1'b0;
          end
        endcase
      end
    end else begin
      n.div = tick ? '0 : r.div + 1'b1;
      if (tick) begin
        n.qtr = r.qtr + 2'h1;
        unique case (r.state)
          // Start: data falls while clock is high
          MST_START: begin
            unique case (r.qtr)
              2'h0: n.sda_oe = 1'b0;
              2'h1: n.scl    = 1'b1;
              2'h2: n.sda_oe = 1'b1;
              2'h3: n.scl    = 1'b0;
            endcase
          end
          // Stop: data rises while clock is high
          MST_STOP: begin
            unique case (r.qtr)
              2'h0: n.sda_oe = 1'b1;
              2'h1: n.scl    = 1'b1;
              2'h2: n.sda_oe = 1'b0;
              2'h3: n.scl    = 1'b1;
            endcase
          end
          // Data bits change only while the clock is low
          MST_BIT: begin
            unique case (r.qtr)
              2'h0: n.scl = 1'b1;
              2'h1: n.scl = 1'b1;
              2'h2: begin
                n.rx  = {r.rx[7:0], r.sda_sy[1]};
                n.scl = 1'b0;
              end
              2'h3: begin
                if (r.bitn != 4'h8) begin
                  n.bitn   = r.bitn + 4'h1;
                  n.tx     = {r.tx[7:0], 1'b1};
                  n.sda_oe = ~r.tx[7];
                end else begin
                  n.sda_oe = 1'b0;
                end
              end
            endcase
          end
          default: n.state = MST_IDLE;
        endcase
        // Primitive ends on the last quarter
        if (r.qtr == 2'h3 && (r.state != MST_BIT || r.bitn == 4'h8)) begin
          n.state = MST_IDLE;
          n.ready = 1'b1;
          n.rsp_v = 1'b1;
          n.rsp_d = r.rx[8:1];
          n.rsp_a = ~r.rx[0];  // Low in the ninth slot means ack
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r        <= '0;
      r.state  <= MST_IDLE;
      r.scl    <= 1'b1;
      r.sda_sy <= 2'h3;
      r.ready  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.scl      = r.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = r.sda_oe;
  assign cmd_ready     = r.ready;
  assign rsp_valid     = r.rsp_v;
  assign rsp_data      = r.rsp_d;
  assign rsp_ack       = r.rsp_a;

endmodule : i2c_bus_master

// ==== i2c_eeprom_device.sv ====
// Summary of operation
// - Page write takes up to 32 same-row bytes
// - Master sends no bytes past row end
// - Data bytes acknowledged while protect input low from start through addressing
// - Protected write: no change, data bytes nacked
// - Byte address increments, wrapping inside row
// - Master ends page write with stop
// - Internal write detaches bus, copies latched bytes
// - Select ignored while busy, acknowledged after
// - Random read repeats same seven select bits
// - Reads ignore the protect input
// - Address counter increments after each read
// - Random read: dummy write, restart, read
// - Current read: select read, byte, counter increments
// - Sequential read: ack continues, nack ends
// - Sequential read wraps to address zero
// - Ninth slot not low: stop sending, standby
// - Array starts with every byte FFh
// - Select acked only on type and pins match
// - Two address bytes, high first, each acked
// - Stop right after write ack starts programming
// - Protect high during addressing marks write protected
`timescale 1ns/1ns
`include "i2c_eeprom_params.svh"
module i2c_eeprom_device
  import i2c_eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES    = `EE_PROG_CYCLES,
  parameter logic [3:0]  DEVICE_TYPE_ID = 4'h6  // Arbitrary type code
) (
  input  wire logic clk,
  input  wire logic srst,
  i2c_link_if.device link,
  input  wire logic write_protect_input,
  input  wire logic chip_select_pin_0,
  input  wire logic chip_select_pin_1,
  input  wire logic chip_select_pin_2,
  output logic      busy
);

  // ----------------------------------------------------------------
  // Types and storage
  // ----------------------------------------------------------------
  localparam int unsigned CW = $clog2(PROG_CYCLES + 1);
  localparam int unsigned AW = `EE_ADDR_W;

  typedef struct packed {
    logic [2:0]   scl_sy;   // [0] first flop, [1] second, [2] previous
    logic [2:0]   sda_sy;   // Same layout as the clock
    logic [1:0]   wp_sy;    // Protect input synchroniser
    logic [2:0]   cs_sy1;   // Chip select pins, first flop
    logic [2:0]   cs_sy2;   // Chip select pins, second flop
    dev_state_t   state;    // Bus activity
    byte_kind_t   kind;     // Byte being received
    logic [3:0]   bitcnt;   // Bits moved in this byte
    logic [7:0]   sh;       // Shift register
    logic         rw;       // Direction from select byte
    logic         prot;     // Write is protected
    logic [AW-1:0] addr;    // Address counter
    logic [31:0]  pvalid;   // Latched page bytes
    logic [CW-1:0] pcnt;    // Program time counter
    logic         sda_oe;   // Pull data low
    logic         busy;     // Internal write running
  } dev_regs_t;

  dev_regs_t r;                              // State
  dev_regs_t n;                              // Next state
  logic [7:0] mem [0:`EE_MEM_BYTES-1];       // Nonvolatile array
  logic [7:0] pbuf [0:`EE_PAGE_BYTES-1];     // Page latches
  logic [7:0] rd_byte;                       // Byte at the counter
  logic       mem_we;                        // Array write strobe
  logic [AW-1:0] mem_wa;                     // Array write address
  logic       buf_we;                        // Page latch strobe
  logic       scl_rise;
  logic       scl_fall;
  logic       scl_high;
  logic       start_seen;
  logic       stop_seen;
  logic       wp;                            // Synchronised protect level

  // Array content at delivery is all ones
  initial begin
    for (int i = 0; i < `EE_MEM_BYTES; i++) begin
      mem[i] = `EE_MEM_ERASED;
    end
  end

  assign rd_byte = mem[r.addr];

  // ----------------------------------------------------------------
  // Bus edge detection, all on synchronised copies
  // ----------------------------------------------------------------
  assign scl_rise   = r.scl_sy[1] & ~r.scl_sy[2];
  assign scl_fall   = ~r.scl_sy[1] & r.scl_sy[2];
  assign scl_high   = r.scl_sy[1] & r.scl_sy[2];
  assign start_seen = scl_high & ~r.sda_sy[1] & r.sda_sy[2];
  assign stop_seen  = scl_high & r.sda_sy[1] & ~r.sda_sy[2];
  assign wp         = r.wp_sy[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = r;
    mem_we   = 1'b0;
    mem_wa   = {r.addr[AW-1:`EE_ROW_LSB], r.pcnt[`EE_ROW_LSB-1:0]};
    buf_we   = 1'b0;
    n.scl_sy = {r.scl_sy[1:0], link.scl};
    n.sda_sy = {r.sda_sy[1:0], link.sda};
    n.wp_sy  = {r.wp_sy[0], write_protect_input};
    n.cs_sy1 = {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
    n.cs_sy2 = r.cs_sy1;

    if (r.state == DEV_PROG) begin
      // Detached from the bus: no start, no ack until done
      n.sda_oe = 1'b0;
      n.pcnt   = r.pcnt + 1'b1;
      // One latched byte per cycle into its row
      if (r.pcnt < CW'(`EE_PAGE_BYTES)) begin
        mem_we = r.pvalid[r.pcnt[`EE_ROW_LSB-1:0]];
      end
      if (r.pcnt == CW'(PROG_CYCLES - 1)) begin
        n.state = DEV_IDLE;
      end
    end else if (start_seen) begin
      // Start or restart: fresh frame, protect sampled from here
      n.state  = DEV_RX;
      n.kind   = KIND_SELECT;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      n.prot   = wp;
      n.pvalid = '0;
    end else if (stop_seen) begin
      n.sda_oe = 1'b0;
      // Program only for a stop in the slot after a data ack
      // The tenth-slot clock has already risen once when the stop shows
      if (r.state == DEV_RX && r.kind == KIND_DATA && r.bitcnt == 4'h1 &&
          (|r.pvalid) && !r.prot) begin
        n.state = DEV_PROG;
        n.pcnt  = '0;
      end else begin
        n.state = DEV_IDLE;
      end
    end else begin
      unique case (r.state)
        DEV_IDLE: n.sda_oe = 1'b0;

        // ------------------------------------------------------------
        // Receiving select, address and data bytes
        // ------------------------------------------------------------
        DEV_RX: begin
          if (r.kind != KIND_DATA) begin
            n.prot = r.prot | wp;  // Sticky until the data phase
          end
          if (scl_rise) begin
            if (r.bitcnt < 4'(`EE_BITS_PER_BYTE)) begin
              n.sh     = {r.sh[6:0], r.sda_sy[1]};
              n.bitcnt = r.bitcnt + 4'h1;
            end else begin
              n.bitcnt = 4'(`EE_ACK_SLOT);
            end
          end
          if (scl_fall && r.bitcnt == 4'(`EE_BITS_PER_BYTE)) begin
            // Decide the ack for the byte just taken
            unique case (r.kind)
              KIND_SELECT: begin
                n.rw     = r.sh[0];
                n.sda_oe = (r.sh[7:4] == DEVICE_TYPE_ID) &&
                           (r.sh[3:1] == r.cs_sy2);
              end
              KIND_ADDR_HI: begin
                // Upper four bits of this byte are ignored
                n.addr[AW-1:8] = r.sh[`EE_ADDR_HI_MSB:0];
                n.sda_oe       = 1'b1;
              end
              KIND_ADDR_LO: begin
                n.addr[7:0] = r.sh;  // Low byte follows high byte
                n.sda_oe    = 1'b1;
              end
              KIND_DATA: begin
                if (!r.prot) begin
                  // Latch, ack, and step inside the row
                  buf_we                           = 1'b1;
                  n.pvalid[r.addr[`EE_ROW_LSB-1:0]] = 1'b1;
                  n.addr[`EE_ROW_LSB-1:0] = r.addr[`EE_ROW_LSB-1:0] + 5'h01;
                  n.sda_oe                         = 1'b1;
                end else begin
                  n.sda_oe = 1'b0;  // Protected: nack, array untouched
                end
              end
            endcase
          end else if (scl_fall && r.bitcnt == 4'(`EE_ACK_SLOT)) begin
            // End of the ack slot: release and pick the next phase
            n.sda_oe = 1'b0;
            n.bitcnt = 4'h0;
            unique case (r.kind)
              KIND_SELECT: begin
                if (!r.sda_oe) begin
                  n.state = DEV_IDLE;  // No match: standby
                end else if (r.rw) begin
                  // Read regardless of protect; first bit now
                  n.state  = DEV_TX;
                  n.sda_oe = ~rd_byte[7];
                  n.sh     = {rd_byte[6:0], 1'b0};
                  n.bitcnt = 4'h1;
                end else begin
                  n.kind = KIND_ADDR_HI;
                end
              end
              KIND_ADDR_HI: n.kind = KIND_ADDR_LO;
              KIND_ADDR_LO: n.kind = KIND_DATA;  // Or restart for a read
              KIND_DATA:    n.kind = KIND_DATA;
            endcase
          end
        end

        // ------------------------------------------------------------
        // Sending read data
        // ------------------------------------------------------------
        DEV_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'h0) begin
              // Next sequential byte, counter already stepped
              n.sda_oe = ~rd_byte[7];
              n.sh     = {rd_byte[6:0], 1'b0};
              n.bitcnt = 4'h1;
            end else if (r.bitcnt < 4'(`EE_BITS_PER_BYTE)) begin
              n.sda_oe = ~r.sh[7];
              n.sh     = {r.sh[6:0], 1'b0};
              n.bitcnt = r.bitcnt + 4'h1;
            end else if (r.bitcnt == 4'(`EE_BITS_PER_BYTE)) begin
              n.sda_oe = 1'b0;  // Let the master answer in the ninth slot
              n.bitcnt = 4'(`EE_ACK_SLOT);
            end
          end
          // Only the ninth rise carries the master's answer, not the last data bit
          if (scl_rise && r.bitcnt == 4'(`EE_ACK_SLOT)) begin
            // Step over all twelve bits, wraps to zero
            n.addr   = r.addr + 12'h001;
            n.bitcnt = 4'h0;
            if (r.sda_sy[1]) begin
              n.state = DEV_IDLE;  // No ack in ninth slot: standby
            end
          end
        end

        default: n.state = DEV_IDLE;
      endcase
    end
    n.busy = (n.state == DEV_PROG);
  end

  // ----------------------------------------------------------------
  // Array and page latches; no reset so content survives srst
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= pbuf[r.pcnt[`EE_ROW_LSB-1:0]];
    end
    if (buf_we) begin
      pbuf[r.addr[`EE_ROW_LSB-1:0]] <= r.sh;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r        <= '0;
      r.state  <= DEV_IDLE;
      r.kind   <= KIND_SELECT;
      r.scl_sy <= 3'h7;  // Idle bus is high; avoids a false edge
      r.sda_sy <= 3'h7;
    end else begin
      r <= n;
    end
  end

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = r.sda_oe;
  assign busy          = r.busy;

endmodule : i2c_eeprom_device

// ==== i2c_eeprom_checker.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Link checker beside the device end
// ----------------------------------------------------------------
module i2c_eeprom_checker #(
  parameter int unsigned PROG_CYCLES    = 400,
  parameter logic [3:0]  DEVICE_TYPE_ID = 4'h6  // Arbitrary type code
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  input wire logic busy,
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2
);
  logic        scl_reg;   // Line levels one cycle back
  logic        sda_reg;
  logic [3:0]  bit_reg;   // Clock rises in the current byte
  logic [3:0]  byte_reg;  // Byte index since start, F when none
  logic [7:0]  sel_reg;   // First byte of the frame
  logic        bsy_reg;   // Busy seen since the start
  logic [15:0] cnt_reg;   // Length of the current busy spell
  logic [3:0]  stop_reg;  // Cycles since the last stop, saturating
  wire start_ev = scl && scl_reg && sda_reg && !sda;
  wire stop_ev  = scl && scl_reg && !sda_reg && sda;
  wire rise     = scl && !scl_reg;

  // Frame tracking; only the master makes start and stop, so the wire tells all
  always_ff @(posedge clk) begin
    scl_reg  <= scl;
    sda_reg  <= sda;
    cnt_reg  <= busy ? cnt_reg + 16'h1 : 16'h0;
    stop_reg <= stop_ev ? 4'h0 : stop_reg + {3'h0, stop_reg != 4'hF};
    bsy_reg  <= (bsy_reg && !start_ev) || busy;
    if (srst || start_ev) begin
      bit_reg  <= 4'h0;
      byte_reg <= srst ? 4'hF : 4'h0;
    end else if (rise) begin
      bit_reg <= (bit_reg == 4'h9) ? 4'h1 : bit_reg + 4'h1;
      if (bit_reg == 4'h9 && byte_reg != 4'hF) begin
        byte_reg <= byte_reg + 4'h1;
      end
      sel_reg <= (byte_reg == 4'h0 && bit_reg < 4'h8) ? {sel_reg[6:0], sda} : sel_reg;
    end
    if (srst) begin
      scl_reg  <= 1'b1;
      sda_reg  <= 1'b1;
      cnt_reg  <= 16'h0;
      stop_reg <= 4'hF;
    end
  end

  // Ninth rise of a select byte; a busy spell ending mid-byte is left out
  sequence sel_slot_s;
    rise && byte_reg == 4'h0 && bit_reg == 4'h8 && (busy || !bsy_reg);
  endsequence

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  reset_quiet_a: assert property ($fell(srst) |-> !sda_s_oe && !busy)
    else $error("device active right after reset");
  busy_detach_a: assert property (busy |-> !sda_s_oe)
    else $error("device drives data while busy");
  busy_hold_a: assert property ($rose(busy) |-> busy[*8])
    else $error("busy spell too short");
  busy_len_a: assert property ($fell(busy) |->
    cnt_reg >= PROG_CYCLES - 1 && cnt_reg <= PROG_CYCLES + 1)
    else $error("busy spell length wrong");
  busy_cause_a: assert property ($rose(busy) |-> stop_reg <= 4'hA)
    else $error("busy without a stop");
  drive_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device data changed while clock high");
  select_quiet_a: assert property (rise && byte_reg == 4'h0 && bit_reg < 4'h8 |-> !sda_s_oe)
    else $error("device drove during select byte");
  select_ack_a: assert property (sel_slot_s |-> sda_s_oe == (!busy &&
    sel_reg[7:1] == {DEVICE_TYPE_ID, chip_select_pin_2, chip_select_pin_1, chip_select_pin_0}))
    else $error("select acknowledge wrong");
endmodule : i2c_eeprom_checker

// ==== i2c_eeprom_page_write_read_tb_top.sv ====
`timescale 1ns/1ns
module i2c_eeprom_page_write_read_tb_top;
  import i2c_eeprom_pkg::*;
  localparam int unsigned PROG = 400;  // Long enough that the first poll lands while busy
  localparam logic [3:0]  TYPE = 4'h6;  // Arbitrary type code
  logic       clk, srst, cmd_valid, cmd_ack_send, cmd_ready, rsp_valid, rsp_ack;
  logic       wp, busy, ak;
  logic [2:0] cs;
  logic [7:0] cmd_data, rsp_data, rd;
  bus_op_t    cmd_op;
  logic [7:0] mem [4096];  // Reference copy of the array
  int         ptr, seed, num_errors, samples_checked;

  i2c_link_if link ();
  i2c_bus_master u_i2c_bus_master (.clk(clk), .srst(srst), .link(link.master),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack_send(cmd_ack_send),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  i2c_eeprom_device #(.PROG_CYCLES(PROG), .DEVICE_TYPE_ID(TYPE)) u_i2c_eeprom_device (
    .clk(clk), .srst(srst), .link(link.device), .write_protect_input(wp),
    .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]), .chip_select_pin_2(cs[2]),
    .busy(busy));
  i2c_eeprom_checker #(.PROG_CYCLES(PROG), .DEVICE_TYPE_ID(TYPE)) u_i2c_eeprom_checker (
    .clk(clk), .srst(srst), .scl(link.scl), .sda(link.sda), .sda_s_oe(link.sda_s_oe),
    .busy(busy), .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]),
    .chip_select_pin_2(cs[2]));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus primitive; request held until taken, answer caught at its pulse
  task automatic op(input bus_op_t o, input logic [7:0] d, input logic a);
    @(negedge clk);
    cmd_valid    = 1'b1;
    cmd_op       = o;
    cmd_data     = d;
    cmd_ack_send = a;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int n = 0; n < 400 && rsp_valid !== 1'b1; n++) @(negedge clk);
    if (rsp_valid !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    rd = rsp_data;
    ak = rsp_ack;
  endtask : op

  // Start, write select and both address bytes
  task automatic frame(input logic [11:0] a, input logic [3:0] junk);
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {TYPE, cs, 1'b0}, 1'b0);
    chk(8'(ak), 8'h01);
    op(OP_WRITE, {junk, a[11:8]}, 1'b0);
    chk(8'(ak), 8'h01);
    op(OP_WRITE, a[7:0], 1'b0);
    chk(8'(ak), 8'h01);
  endtask : frame

  // Page write, then poll until the device answers again
  task automatic page_write(input logic [11:0] a, input int n, input logic [3:0] junk,
                            input logic pw);
    logic [7:0] d;
    wp = pw;
    frame(a, junk);
    wp = 1'b0;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      op(OP_WRITE, d, 1'b0);
      chk(8'(ak), 8'(!pw));
      if (!pw) mem[{a[11:5], 5'(a[4:0] + i)}] = d;
    end
    op(OP_STOP, 8'h00, 1'b0);
    if (!pw) ptr = {a[11:5], 5'(a[4:0] + n)};
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {TYPE, cs, 1'b0}, 1'b0);
    chk(8'(ak), 8'(pw));
    for (int i = 0; i < 40 && ak !== 1'b1; i++) begin
      op(OP_STOP, 8'h00, 1'b0);
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, {TYPE, cs, 1'b0}, 1'b0);
    end
    chk(8'(ak), 8'h01);
    op(OP_STOP, 8'h00, 1'b0);
  endtask : page_write

  // Random or current read of n bytes, last one not acknowledged
  task automatic rd_seq(input logic [11:0] a, input logic rnd, input int n);
    if (rnd) begin
      frame(a, 4'h0);
      ptr = a;
    end
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {TYPE, cs, 1'b1}, 1'b0);
    chk(8'(ak), 8'h01);
    for (int i = 0; i < n; i++) begin
      op(OP_READ, 8'h00, i < n - 1);
      chk(rd, mem[ptr]);
      ptr = (ptr + 1) % 4096;
    end
    op(OP_STOP, 8'h00, 1'b0);
  endtask : rd_seq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 8648;
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack_send = 1'b0;
    wp = 1'b0;
    ptr = 0;
    num_errors = 0;
    samples_checked = 0;
    cs = 3'($random(seed));
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rd_seq(12'hFFE, 1'b1, 4);
    page_write(12'h040, 32, 4'($random(seed)), 1'b0);
    rd_seq(12'h040, 1'b1, 32);
    page_write(12'h07B, 5, 4'h0, 1'b0);
    rd_seq(12'h000, 1'b0, 2);
    page_write(12'h040, 3, 4'h0, 1'b1);
    wp = 1'b1;
    rd_seq(12'h040, 1'b1, 3);
    wp = 1'b0;
    rd_seq(12'h000, 1'b0, 1);
    // Wrong chip pins, then wrong type code
    for (int k = 0; k < 2; k++) begin
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, k ? {4'h9, cs, 1'b1} : {TYPE, ~cs, 1'b0}, 1'b0);
      chk(8'(ak), 8'h00);
      op(OP_STOP, 8'h00, 1'b0);
    end
    close_out();
  end

  // Hang guard, about four times the expected run
  initial begin
    #4000000;
    num_errors++;
    close_out();
  end
endmodule : i2c_eeprom_page_write_read_tb_top
